// ### hdl/sdip_params.svh
// Purpose: constants for the serial converter input port
// Assumes: included by every design file of the block
// Notes: widths and the latch reset value; the port has no timing counts of its own
`ifndef SDIP_PARAMS_SVH
`define SDIP_PARAMS_SVH
`define SDIP_WORD_BITS 16
`define SDIP_SYNC_STAGES 2
`define SDIP_LATCH_RESET 16'h0000
`endif

// ### hdl/sdip_pkg.sv
// Purpose: types shared by the serial converter input port
// Assumes: sdip_params.svh holds the widths
// Notes: word is twos complement, sign bit first on the wire
`include "sdip_params.svh"
package sdip_pkg;
	typedef logic [`SDIP_WORD_BITS-1:0] sdip_word_type;
	typedef struct packed {
		logic bit_clk;
		logic data;
		logic load;
	} sdip_pins_type;
	typedef struct packed {
		sdip_pins_type s1;
		sdip_pins_type s2;
	} sdip_sync_type;
	typedef struct packed {
		sdip_pins_type prev;
		sdip_word_type shift;
		sdip_word_type latch;
		logic loaded;
	} sdip_state_type;
endpackage

// ### hdl/sdip_port.sv
// Purpose: serial input port and input latch of a 16-bit converter
// Assumes: bit clock well below sys_clk_i/4 (320 ns period in bench)
// Notes: reset exists only for simulation; the latch starts at midscale
`timescale 1ns/100ps
`include "sdip_params.svh"
module sdip_port
	import sdip_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic bit_clk_i,
	input wire logic serial_data_i,
	input wire logic word_load_strobe_i,
	output sdip_word_type dac_code_o,
	output logic dac_midscale_o,
	output logic word_loaded_o
);
	sdip_pins_type pins_raw;
	sdip_pins_type pins;
	sdip_state_type st_q;
	sdip_state_type st_d;
	logic clk_fall;
	logic load_fall;

	assign pins_raw.bit_clk = bit_clk_i;
	assign pins_raw.data = serial_data_i;
	assign pins_raw.load = word_load_strobe_i;

	sdip_sync u_sync (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.pins_i(pins_raw),
		.pins_o(pins)
	);

	// data passes the same two stages as the clock, so it stays aligned
	assign clk_fall = st_q.prev.bit_clk & ~pins.bit_clk;
	assign load_fall = st_q.prev.load & ~pins.load;

	always_comb begin
		st_d = st_q;
		st_d.prev = pins;
		st_d.loaded = 1'b0;
		if (clk_fall) begin
			st_d.shift = {st_q.shift[`SDIP_WORD_BITS-2:0], pins.data};
		end
		// strobe takes the word before any bit arriving in the same cycle
		if (load_fall) begin
			st_d.latch = st_q.shift;
			st_d.loaded = 1'b1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			st_q.prev <= '1;
			st_q.shift <= '0;
			st_q.latch <= `SDIP_LATCH_RESET;
			st_q.loaded <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	assign dac_code_o = st_q.latch;
	assign dac_midscale_o = (st_q.latch == '0);
	assign word_loaded_o = st_q.loaded;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);

	shift_on_fall_a: assert property (clk_fall |=>
		st_q.shift[0] == $past(pins.data))
		else $error("bit not shifted on clock fall");
	shift_hold_a: assert property (!clk_fall |=>
		st_q.shift == $past(st_q.shift))
		else $error("shift register moved without clock fall");
	shift_order_a: assert property (clk_fall |=>
		st_q.shift[15:1] == $past(st_q.shift[14:0]))
		else $error("shift order wrong");
	load_copy_a: assert property (load_fall |=>
		dac_code_o == $past(st_q.shift) && word_loaded_o)
		else $error("latch not loaded on strobe fall");
	latch_hold_a: assert property (!load_fall |=>
		$stable(dac_code_o) && !word_loaded_o)
		else $error("latch changed without strobe");
	midscale_flag_a: assert property (
		dac_midscale_o == (dac_code_o == 16'h0000))
		else $error("midscale flag wrong");
	reset_mid_a: assert property (disable iff (1'b0)
		!reset_n_i |=> dac_code_o == 16'h0000)
		else $error("latch not midscale after reset");
	no_fall_reset_a: assert property (disable iff (1'b0)
		!reset_n_i |=> !word_loaded_o)
		else $error("load pulse during reset");

	load_seen_c: cover property (load_fall ##1 word_loaded_o);
	neg_word_c: cover property (word_loaded_o && dac_code_o[15]);
	mid_word_c: cover property (word_loaded_o && dac_midscale_o);
endmodule

// ### hdl/sdip_sync.sv
// Purpose: two-stage synchroniser for the three serial pins
// Assumes: pins are asynchronous to sys_clk_i
// Notes: first stage is read only by the second
`timescale 1ns/100ps
`include "sdip_params.svh"
module sdip_sync
	import sdip_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire sdip_pins_type pins_i,
	output sdip_pins_type pins_o
);
	sdip_sync_type sync_q;
	sdip_sync_type sync_d;

	always_comb begin
		sync_d = sync_q;
		sync_d.s1 = pins_i;
		sync_d.s2 = sync_q.s1;
	end

	// idle levels high so no false falling edge after reset
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			sync_q <= '1;
		end else begin
			sync_q <= sync_d;
		end
	end

	assign pins_o = sync_q.s2;
endmodule

// ### verif/sdip_ctrl_model.sv
// Purpose: serial controller model driving the port pins
// Assumes: send is entered just after a sys clock fall
// Notes: data flips once its hold ends, there is no pull on it
`timescale 1ns/100ps
module sdip_ctrl_model (
	output logic bit_clk_o,
	output logic data_o,
	output logic load_o
);
	initial begin
		bit_clk_o = 1'h1;
		data_o = 1'h0;
		load_o = 1'h1;
	end
	task automatic send(input logic [31:0] w, input int n, input bit ld);
		for (int i = n - 1; i >= 0; i--) begin
			data_o = w[i];
			#80 bit_clk_o = 1'h0;
			#80 data_o = ~data_o;
			#80 bit_clk_o = 1'h1;
			#80;
		end
		if (ld) begin
			load_o = 1'h0;
			#160 load_o = 1'h1;
		end
	endtask
endmodule

// ### verif/sdip_port_tb.sv
// Purpose: bench for the serial converter input port
// Assumes: 25 MHz system clock, 320 ns bit clock
// Notes: pins come from the controller model
`timescale 1ns/100ps
module sdip_port_tb import sdip_pkg::*;;
	logic sys_clk = 1'h0;
	logic reset_n = 1'h0;
	logic bclk, sdat, ld, mid, pulse;
	sdip_word_type code;
	int n_fail = 0;
	int num_checks = 0;
	always #20 sys_clk = ~sys_clk;
	sdip_ctrl_model i_sdip_ctrl_model (.bit_clk_o(bclk), .data_o(sdat),
		.load_o(ld));
	sdip_port i_sdip_port (.sys_clk_i(sys_clk), .reset_n_i(reset_n),
		.bit_clk_i(bclk), .serial_data_i(sdat), .word_load_strobe_i(ld),
		.dac_code_o(code), .dac_midscale_o(mid), .word_loaded_o(pulse));
	task automatic print_verdict;
		$display("checks %0d failures %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(string s, logic [15:0] e, logic [15:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s exp %h got %h", s, e, g);
		end
	endtask
	// waits for the load pulse only when a strobe is sent
	task automatic run(logic [31:0] w, int n, bit l, logic [15:0] e);
		int k;
		k = 0;
		@(negedge sys_clk);
		fork
			i_sdip_ctrl_model.send(w, n, l);
			while (l && pulse !== 1'h1 && k < 200) begin
				@(negedge sys_clk);
				k++;
			end
		join
		if (k == 200) begin
			check("load pulse", 16'h1, 16'h0);
			print_verdict();
		end
		check("code", e, code);
		check("midscale", {15'h0, e == 16'h0}, {15'h0, mid});
	endtask
	initial begin
		repeat (20) @(negedge sys_clk);
		reset_n = 1'h1;
		check("reset code", 16'h0, code);
		run(32'h8001, 16, 1, 16'h8001);
		run(32'hFA5C3, 20, 1, 16'hA5C3);
		run(32'h1234, 16, 0, 16'hA5C3);
		run(32'h0, 16, 1, 16'h0);
		print_verdict();
	end
endmodule
